// ==== vca_pkg.sv ====
package vca_pkg;
    // ======================================================================
    // register indices within the crt timing controller port
    // ======================================================================
    localparam logic [7:0] IDX_VERTICAL_OVERFLOW   = 8'h07;
    localparam logic [7:0] IDX_CELL_HEIGHT_OVF     = 8'h09;
    localparam logic [7:0] IDX_VSYNC_END_PROTECT   = 8'h11;
    localparam logic [7:0] IDX_VERTICAL_DISPLAY_END = 8'h12;
    localparam logic [7:0] IDX_ROW_PITCH_OFFSET    = 8'h13;
    localparam logic [7:0] IDX_UNDERLINE_DWORD     = 8'h14;
    localparam logic [7:0] IDX_VERTICAL_BLANK_START = 8'h15;
    localparam logic [7:0] IDX_VERTICAL_BLANK_END  = 8'h16;
    localparam logic [7:0] IDX_CRT_MODE_CONTROL    = 8'h17;
    localparam logic [7:0] IDX_SPLIT_LINE_COMPARE  = 8'h18;
    localparam logic [7:0] IDX_BLANK_END_EXT       = 8'h1a;
    localparam logic [7:0] IDX_EXT_DISPLAY_CONTROL = 8'h1b;
    localparam logic [7:0] IDX_PROTECT_LIMIT       = 8'h07;
    // ======================================================================
    // i/o port addresses (low 4 bits select index or data)
    // ======================================================================
    localparam logic [15:0] PORT_COLOUR_BASE = 16'h03d0;
    localparam logic [15:0] PORT_MONO_BASE   = 16'h03b0;
    localparam logic [3:0]  PORT_INDEX_OFS   = 4'h4;
    localparam logic [3:0]  PORT_DATA_OFS    = 4'h5;
    // ======================================================================
    // field positions
    // ======================================================================
    localparam int VO_VDE8   = 1;
    localparam int VO_VBS8   = 3;
    localparam int VO_LC8    = 4;
    localparam int CH_LC9    = 6;
    localparam int CH_VBS9   = 5;
    localparam int VP_PROT   = 7;
    localparam int UD_DWORD  = 6;
    localparam int UD_CNT4   = 5;
    localparam int MC_TIMING = 7;
    localparam int MC_BYTE   = 6;
    localparam int MC_WRAP   = 5;
    localparam int MC_CNT2   = 3;
    localparam int MC_VDBL   = 2;
    localparam int MC_ROWSEL = 1;
    localparam int MC_CGA    = 0;
    localparam int EX_PITCH8 = 4;
    localparam int EX_VBEXT  = 5;
    localparam int BE_LO     = 6;
    localparam int AW        = 16;
    localparam int LW        = 11;
    localparam logic [7:0] REG_RESET = 8'h00;
endpackage : vca_pkg

// ==== vca_crt_timing_controller_vert.sv ====
// Operation
// - hold 8-bit display end, ninth elsewhere
// - row start plus pitch each new line but the first of the frame
// - pitch nine bits, top from extension
// - pitch shifted by one or two
// - doubleword rotates counter left two
// - doubleword clear: byte/word bit decides
// - five-bit underline row, text only
// - blank starts at blank start line
// - blank ends at 8/10-bit match
// - clearing timing enable halts timing logic
// - byte mode unrotated, word rotated one
// - wrap bit picks 16 or 14 bits
// - count-by-two halves address clock
// - vertical doubling halves scanline clock
// - row-scan bit 1 replaces counter 14 unless bit 0 does
// - row-scan bit 0 replaces counter 14
// - split screen lower part starts at zero
// - line compare eight bits plus two
// - indexed port at 3d5, mono 3b5
// - write protect spares line compare bit
module vca_crt_timing_controller_vert
    import vca_pkg::*;
#(
    parameter int ROWS_PER_CELL = 16
) (
    input  wire logic          clk,
    input  wire logic          rst_n,
    input  wire logic          io_wr,
    input  wire logic          io_rd,
    input  wire logic [15:0]   io_addr,
    input  wire logic [7:0]    io_wdata,
    input  wire logic          mono_mode,
    input  wire logic          char_clk_tick,
    input  wire logic          hsync_tick,
    input  wire logic          vsync_tick,
    input  wire logic [AW-1:0] start_address,
    input  wire logic          text_mode,
    output logic [7:0]         io_rdata,
    output logic               io_rvalid,
    output logic [AW-1:0]      mem_addr,
    output logic               blank_active,
    output logic               display_active,
    output logic               underline_line,
    output logic [4:0]         row_scan
);
    // ======================================================================
    // register file
    // ======================================================================
    logic [7:0] crt_index;
    logic [7:0] vertical_overflow_reg;
    logic [7:0] cell_height_overflow_reg;
    logic [7:0] vsync_end_and_protect_reg;
    logic [7:0] vertical_display_end;
    logic [7:0] row_pitch_offset;
    logic [7:0] underline_row_and_dword_ctrl;
    logic [7:0] vertical_blank_start;
    logic [7:0] vertical_blank_end;
    logic [7:0] crt_mode_control;
    logic [7:0] split_line_compare;
    logic [7:0] blank_end_extension_reg;
    logic [7:0] extended_display_control;

    logic [15:0] port_base;
    logic        idx_sel;
    logic        dat_sel;
    logic        protect;
    assign port_base = mono_mode ? PORT_MONO_BASE : PORT_COLOUR_BASE;
    assign idx_sel   = (io_addr == (port_base | {12'h000, PORT_INDEX_OFS}));
    assign dat_sel   = (io_addr == (port_base | {12'h000, PORT_DATA_OFS}));
    assign protect   = vsync_end_and_protect_reg[VP_PROT];

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            crt_index <= REG_RESET;
        end else if (io_wr && idx_sel) begin
            crt_index <= io_wdata;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            vertical_overflow_reg        <= REG_RESET;
            cell_height_overflow_reg     <= REG_RESET;
            vsync_end_and_protect_reg    <= REG_RESET;
            vertical_display_end         <= REG_RESET;
            row_pitch_offset             <= REG_RESET;
            underline_row_and_dword_ctrl <= REG_RESET;
            vertical_blank_start         <= REG_RESET;
            vertical_blank_end           <= REG_RESET;
            crt_mode_control             <= REG_RESET;
            split_line_compare           <= REG_RESET;
            blank_end_extension_reg      <= REG_RESET;
            extended_display_control     <= REG_RESET;
        end else if (io_wr && dat_sel) begin
            unique case (crt_index)
                IDX_VERTICAL_OVERFLOW: begin
                    if (protect) begin
                        vertical_overflow_reg[VO_LC8] <= io_wdata[VO_LC8];
                    end else begin
                        vertical_overflow_reg <= io_wdata;
                    end
                end
                IDX_CELL_HEIGHT_OVF:      cell_height_overflow_reg     <= io_wdata;
                IDX_VSYNC_END_PROTECT:    vsync_end_and_protect_reg    <= io_wdata;
                IDX_VERTICAL_DISPLAY_END: vertical_display_end         <= io_wdata;
                IDX_ROW_PITCH_OFFSET:     row_pitch_offset             <= io_wdata;
                IDX_UNDERLINE_DWORD:      underline_row_and_dword_ctrl <= io_wdata;
                IDX_VERTICAL_BLANK_START: vertical_blank_start         <= io_wdata;
                IDX_VERTICAL_BLANK_END:   vertical_blank_end           <= io_wdata;
                IDX_CRT_MODE_CONTROL:     crt_mode_control             <= io_wdata;
                IDX_SPLIT_LINE_COMPARE:   split_line_compare           <= io_wdata;
                IDX_BLANK_END_EXT:        blank_end_extension_reg      <= io_wdata;
                IDX_EXT_DISPLAY_CONTROL:  extended_display_control     <= io_wdata;
                default: ;
            endcase
        end
    end

    // index register readable at the index port; unknown indices read zero
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            io_rdata  <= 8'h00;
            io_rvalid <= 1'b0;
        end else begin
            io_rvalid <= io_rd && (idx_sel || dat_sel);
            if (io_rd && idx_sel) begin
                io_rdata <= crt_index;
            end else if (io_rd && dat_sel) begin
                unique case (crt_index)
                    IDX_VERTICAL_OVERFLOW:    io_rdata <= vertical_overflow_reg;
                    IDX_CELL_HEIGHT_OVF:      io_rdata <= cell_height_overflow_reg;
                    IDX_VSYNC_END_PROTECT:    io_rdata <= vsync_end_and_protect_reg;
                    IDX_VERTICAL_DISPLAY_END: io_rdata <= vertical_display_end;
                    IDX_ROW_PITCH_OFFSET:     io_rdata <= row_pitch_offset;
                    IDX_UNDERLINE_DWORD:      io_rdata <= underline_row_and_dword_ctrl;
                    IDX_VERTICAL_BLANK_START: io_rdata <= vertical_blank_start;
                    IDX_VERTICAL_BLANK_END:   io_rdata <= vertical_blank_end;
                    IDX_CRT_MODE_CONTROL:     io_rdata <= crt_mode_control;
                    IDX_SPLIT_LINE_COMPARE:   io_rdata <= split_line_compare;
                    IDX_BLANK_END_EXT:        io_rdata <= blank_end_extension_reg;
                    IDX_EXT_DISPLAY_CONTROL:  io_rdata <= extended_display_control;
                    default:                  io_rdata <= 8'h00;
                endcase
            end
        end
    end

    // ======================================================================
    // assembled fields
    // ======================================================================
    logic          timing_on;
    logic [9:0]    disp_end;
    logic [9:0]    blank_start;
    logic [9:0]    blank_end;
    logic [9:0]    line_cmp;
    logic [8:0]    pitch;
    logic [AW-1:0] pitch_step;
    logic          dword;
    logic          byte_mode;

    assign timing_on  = crt_mode_control[MC_TIMING];
    assign disp_end   = {1'b0, vertical_overflow_reg[VO_VDE8], vertical_display_end};
    assign blank_start = {cell_height_overflow_reg[CH_VBS9],
                          vertical_overflow_reg[VO_VBS8], vertical_blank_start};
    assign blank_end  = extended_display_control[EX_VBEXT]
                      ? {blank_end_extension_reg[BE_LO+1:BE_LO], vertical_blank_end}
                      : {2'b00, vertical_blank_end};
    assign line_cmp   = {cell_height_overflow_reg[CH_LC9],
                         vertical_overflow_reg[VO_LC8], split_line_compare};
    assign pitch      = {extended_display_control[EX_PITCH8], row_pitch_offset};
    assign dword      = underline_row_and_dword_ctrl[UD_DWORD];
    assign byte_mode  = crt_mode_control[MC_BYTE];
    assign pitch_step = byte_mode ? AW'({pitch, 1'b0}) : AW'({pitch, 2'b00});

    // ======================================================================
    // scanline and row-scan counters
    // ======================================================================
    logic [LW-1:0] scanline;
    logic [4:0]    row_cnt;
    logic          hs_half;
    logic          line_step;
    logic          frame_first;
    logic [9:0]    line_cmp_pos;

    assign line_step    = hsync_tick && (!crt_mode_control[MC_VDBL] || hs_half);
    assign line_cmp_pos = scanline[9:0];

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            scanline    <= '0;
            hs_half     <= 1'b0;
            row_cnt     <= 5'h00;
            frame_first <= 1'b1;
        end else if (timing_on) begin
            if (vsync_tick) begin
                scanline    <= '0;
                hs_half     <= 1'b0;
                row_cnt     <= 5'h00;
                frame_first <= 1'b1;
            end else if (hsync_tick) begin
                hs_half <= !hs_half;
                if (line_step) begin
                    scanline    <= scanline + 1'b1;
                    frame_first <= 1'b0;
                    row_cnt     <= (row_cnt == 5'(ROWS_PER_CELL - 1)) ? 5'h00
                                                                    : row_cnt + 1'b1;
                end
            end
        end
    end

    // ======================================================================
    // display end and blanking
    // ======================================================================
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            display_active <= 1'b0;
            blank_active   <= 1'b0;
            underline_line <= 1'b0;
            row_scan       <= 5'h00;
        end else if (timing_on) begin
            display_active <= (line_cmp_pos <= disp_end);
            if (line_cmp_pos == blank_start) begin
                blank_active <= 1'b1;
            end else if ((extended_display_control[EX_VBEXT] ? line_cmp_pos
                          : {2'b00, line_cmp_pos[7:0]}) == blank_end) begin
                blank_active <= 1'b0;
            end
            underline_line <= text_mode
                && (row_cnt == underline_row_and_dword_ctrl[4:0]);
            row_scan <= row_cnt;
        end
    end

    // ======================================================================
    // address counter
    // ======================================================================
    logic [AW-1:0] row_start;
    logic [AW-1:0] addr_cnt;
    logic [1:0]    cclk_div;
    logic          addr_step;
    logic          split_hit;
    logic [AW-1:0] mapped;

    assign split_hit = (line_cmp_pos == line_cmp);
    // divide by four takes priority over divide by two; neither set steps every tick
    assign addr_step = char_clk_tick
        && (underline_row_and_dword_ctrl[UD_CNT4] ? (cclk_div == 2'd3)
            : crt_mode_control[MC_CNT2] ? cclk_div[0] : 1'b1);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            row_start <= '0;
            addr_cnt  <= '0;
            cclk_div  <= 2'd0;
        end else if (timing_on) begin
            if (vsync_tick) begin
                row_start <= start_address;
                addr_cnt  <= start_address;
                cclk_div  <= 2'd0;
            end else if (line_step) begin
                cclk_div <= 2'd0;
                if (split_hit) begin
                    row_start <= '0;
                    addr_cnt  <= '0;
                end else if (!frame_first) begin
                    row_start <= row_start + pitch_step;
                    addr_cnt  <= row_start + pitch_step;
                end else begin
                    addr_cnt <= row_start;
                end
            end else if (char_clk_tick) begin
                cclk_div <= cclk_div + 2'd1;
                if (addr_step) begin
                    addr_cnt <= addr_cnt + 1'b1;
                end
            end
        end
    end

    always_comb begin
        if (dword) begin
            mapped = {addr_cnt[AW-3:0], addr_cnt[13:12]};
        end else if (byte_mode) begin
            mapped = addr_cnt;
        end else if (crt_mode_control[MC_WRAP]) begin
            mapped = {addr_cnt[AW-2:0], addr_cnt[15]};
        end else begin
            mapped = {addr_cnt[AW-2:0], addr_cnt[13]};
        end
        if (!crt_mode_control[MC_ROWSEL]) begin
            mapped[14] = row_cnt[1];
        end
        if (!crt_mode_control[MC_CGA]) begin
            mapped[14] = row_cnt[0];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mem_addr <= '0;
        end else if (timing_on) begin
            mem_addr <= mapped;
        end
    end
endmodule : vca_crt_timing_controller_vert

// ==== vca_crt_timing_controller_vert_chk.sv ====
module vca_crt_timing_controller_vert_chk
    import vca_pkg::*;
#(
    parameter int ROWS_PER_CELL = 16
) (
    input wire logic          clk,
    input wire logic          rst_n,
    input wire logic          io_wr,
    input wire logic          io_rd,
    input wire logic [15:0]   io_addr,
    input wire logic [7:0]    io_wdata,
    input wire logic          mono_mode,
    input wire logic          text_mode,
    input wire logic          io_rvalid,
    input wire logic [AW-1:0] mem_addr,
    input wire logic          blank_active,
    input wire logic          display_active,
    input wire logic          underline_line,
    input wire logic [4:0]    row_scan
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==================================================================
    // shadow copies of the controls, rebuilt from the port traffic
    // ==================================================================
    logic [15:0] base;
    logic        hit_i;
    logic        hit_d;
    logic [7:0]  idx;
    logic [7:0]  mc;
    logic [7:0]  ul;
    assign base  = mono_mode ? PORT_MONO_BASE : PORT_COLOUR_BASE;
    assign hit_i = io_addr == {base[15:4], PORT_INDEX_OFS};
    assign hit_d = io_addr == {base[15:4], PORT_DATA_OFS};
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            idx <= REG_RESET;
            mc  <= REG_RESET;
            ul  <= REG_RESET;
        end else if (io_wr && hit_i) begin
            idx <= io_wdata;
        end else if (io_wr && hit_d && idx == IDX_CRT_MODE_CONTROL) begin
            mc <= io_wdata;
        end else if (io_wr && hit_d && idx == IDX_UNDERLINE_DWORD) begin
            ul <= io_wdata;
        end
    end
    // ==================================================================
    // properties
    // ==================================================================
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    // outputs lag a control write by one cycle, so demand two quiet cycles
    sequence held_on;
        mc[MC_TIMING] && $past(mc[MC_TIMING]) && $stable(mc) && $stable(ul);
    endsequence
    rd_answer_a: assert property (io_rd && (hit_i || hit_d) |=> io_rvalid)
        else $error("read of a controller port got no answer");
    rd_ignore_a: assert property (io_rd && !hit_i && !hit_d |=> !io_rvalid)
        else $error("read of a foreign port was answered");
    rd_cause_a: assert property (io_rvalid |-> $past(io_rd && (hit_i || hit_d)))
        else $error("read valid without a read");
    reset_clear_a: assert property ($rose(rst_n) |-> mem_addr == 16'h0000
        && !blank_active && !display_active && row_scan == 5'h00)
        else $error("outputs not cleared by reset");
    frozen_out_a: assert property (!mc[MC_TIMING] && !$past(mc[MC_TIMING])
        && !$past(mc[MC_TIMING], 2) |-> $stable(mem_addr) && $stable(row_scan)
        && $stable(blank_active) && $stable(display_active))
        else $error("timing moved while disabled");
    row_limit_a: assert property (int'(row_scan) < ROWS_PER_CELL)
        else $error("row scan beyond cell height");
    under_text_a: assert property (held_on ##0 (!text_mode && !$past(text_mode))
        |-> !underline_line)
        else $error("underline outside text mode");
    under_row_a: assert property (held_on ##0 (text_mode && $past(text_mode))
        |-> underline_line == (row_scan == ul[4:0]))
        else $error("underline on wrong row");
    cga_swap_a: assert property (held_on ##0 (mc[MC_BYTE] && !mc[MC_CGA]
        && !ul[UD_DWORD]) |-> mem_addr[14] == row_scan[0])
        else $error("row scan bit 0 not on address bit 14");
    row_swap_a: assert property (held_on ##0 (mc[MC_BYTE] && mc[MC_CGA]
        && !mc[MC_ROWSEL] && !ul[UD_DWORD]) |-> mem_addr[14] == row_scan[1])
        else $error("row scan bit 1 not on address bit 14");
endmodule : vca_crt_timing_controller_vert_chk

// ==== vca_scan_src.sv ====
module vca_scan_src (
    input  wire logic clk,
    output logic      char_clk_tick,
    output logic      hsync_tick,
    output logic      vsync_tick
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        char_clk_tick = 1'b0;
        hsync_tick    = 1'b0;
        vsync_tick    = 1'b0;
    end
    task automatic frame();
        @(posedge clk);
        #1 vsync_tick = 1'b1;
        @(posedge clk);
        #1 vsync_tick = 1'b0;
        repeat (2) @(posedge clk);
        #1;
    endtask : frame
    // one pulse per line; random gaps act as a slow monitor
    task automatic lines(input int n);
        repeat (n) begin
            @(posedge clk);
            #1 hsync_tick = 1'b1;
            @(posedge clk);
            #1 hsync_tick = 1'b0;
            repeat (2 + $urandom_range(3)) @(posedge clk);
        end
        #1;
    endtask : lines
    task automatic chars(input int n);
        repeat (n) begin
            @(posedge clk);
            #1 char_clk_tick = 1'b1;
            @(posedge clk);
            #1 char_clk_tick = 1'b0;
        end
        repeat (2) @(posedge clk);
        #1;
    endtask : chars
endmodule : vca_scan_src

// ==== vca_crt_timing_controller_vert_bench.sv ====
module vca_crt_timing_controller_vert_bench
    import vca_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'b0, rst_n = 1'b0, io_wr = 1'b0, io_rd = 1'b0;
    logic        mono_mode = 1'b0, text_mode = 1'b0, got_v;
    logic [15:0] io_addr = 16'h0000, start_address = 16'h0000, mem_addr, s, c;
    logic [7:0]  io_wdata = 8'h00, io_rdata, rd_v, v;
    logic [8:0]  p;
    logic        io_rvalid, blank_active, display_active, underline_line;
    logic        char_clk_tick, hsync_tick, vsync_tick;
    logic [4:0]  row_scan;
    int          n_errors = 0, comparisons = 0, cyc = 0;
    logic [7:0]  idx_t[7] = '{8'h12, 8'h13, 8'h14, 8'h15, 8'h16, 8'h17, 8'h18};
    logic [7:0]  mc_t[6] = '{8'hc3, 8'ha3, 8'h83, 8'hc3, 8'hc2, 8'hc1};
    logic [7:0]  ud_t[6] = '{8'h00, 8'h00, 8'h00, 8'h60, 8'h00, 8'h00};
    logic [15:0] mk_t[6] = '{16'hffff, 16'hffff, 16'h3fff, 16'h0003, 16'hbfff, 16'hbfff};
    int          sh_t[6] = '{1, 2, 2, 1, 1, 1};
    always #12.5 clk = ~clk;
    vca_crt_timing_controller_vert #(.ROWS_PER_CELL(16)) vca_crt_timing_controller_vert_i (.clk, .rst_n, .io_wr, .io_rd,
        .io_addr, .io_wdata, .mono_mode, .char_clk_tick, .hsync_tick, .vsync_tick,
        .start_address, .text_mode, .io_rdata, .io_rvalid, .mem_addr, .blank_active,
        .display_active, .underline_line, .row_scan);
    vca_scan_src vca_scan_src_i (.clk, .char_clk_tick, .hsync_tick, .vsync_tick);
    // ==================================================================
    // bus and compare helpers
    // ==================================================================
    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    function automatic logic [15:0] port(input logic [3:0] o);
        port = {(mono_mode ? PORT_MONO_BASE[15:4] : PORT_COLOUR_BASE[15:4]), o};
    endfunction : port
    task automatic acc(input logic wr, input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        #1 io_wr = wr;
        io_rd = !wr;
        io_addr = a;
        io_wdata = d;
        @(posedge clk);
        #1 io_wr = 1'b0;
        io_rd = 1'b0;
        got_v = io_rvalid;
        rd_v = io_rdata;
    endtask : acc
    task automatic wreg(input logic [7:0] i, input logic [7:0] d);
        acc(1'b1, port(PORT_INDEX_OFS), i);
        acc(1'b1, port(PORT_DATA_OFS), d);
    endtask : wreg
    task automatic rreg(input logic [7:0] i);
        acc(1'b1, port(PORT_INDEX_OFS), i);
        acc(1'b0, port(PORT_DATA_OFS), 8'h00);
    endtask : rreg
    // split point and display end pushed far down; pitch top bit in the extension
    task automatic setup(input logic [7:0] m, input logic [7:0] u, input logic [8:0] pp);
        wreg(8'h07, 8'h12);
        wreg(8'h09, 8'h40);
        wreg(8'h12, 8'hff);
        wreg(8'h18, 8'hff);
        wreg(8'h13, pp[7:0]);
        wreg(8'h1b, {3'b000, pp[8], 4'h0});
        wreg(8'h14, u);
        wreg(8'h17, m);
    endtask : setup
    function automatic logic [15:0] fetch(input int m, input logic [15:0] a);
        case (m)
            1: fetch = {a[14:0], a[15]};
            2: fetch = {2'b00, a[12:0], a[13]};
            3: fetch = {14'h0000, a[13:12]};
            default: fetch = a;
        endcase
    endfunction : fetch
    task automatic test_done();
        if (n_errors == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : test_done
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_errors++;
            test_done();
        end
    end
    // ==================================================================
    // scenarios
    // ==================================================================
    initial begin
        void'($urandom(51));
        repeat (4) @(posedge clk);
        #1 rst_n = 1'b1;
        start_address = 16'h1234;
        vca_scan_src_i.frame();
        vca_scan_src_i.lines(2);
        chk("frozen", mem_addr, 16'h0000);
        foreach (idx_t[i]) begin
            rreg(idx_t[i]);
            chk("reset", {8'h00, rd_v}, {8'h00, REG_RESET});
            v = 8'($urandom);
            wreg(idx_t[i], v);
            rreg(idx_t[i]);
            chk("readback", {8'h00, rd_v}, {8'h00, v});
        end
        wreg(8'h20, 8'ha5);
        rreg(8'h20);
        chk("unknown", {8'h00, rd_v}, 16'h0000);
        acc(1'b0, 16'h03c5, 8'h00);
        chk("foreign", {15'h0, got_v}, 16'h0000);
        mono_mode = 1'b1;
        wreg(8'h13, 8'h5a);
        rreg(8'h13);
        chk("mono", {8'h00, rd_v}, 16'h005a);
        acc(1'b0, 16'h03d5, 8'h00);
        chk("colour_off", {15'h0, got_v}, 16'h0000);
        mono_mode = 1'b0;
        wreg(8'h11, 8'h80);
        wreg(8'h07, 8'hff);
        rreg(8'h07);
        chk("protect", {8'h00, rd_v}, 16'h0010);
        wreg(8'h11, 8'h00);
        // count-by-four paired with doubleword in the mode table
        for (int m = 0; m < 6; m++) begin
            p = (m == 0) ? 9'h1ff : 9'($urandom);
            s = (m == 0) ? 16'hfff0 : 16'($urandom);
            start_address = s;
            text_mode = 1'($urandom);
            setup(mc_t[m], ud_t[m] | 8'($urandom_range(3)), p);
            vca_scan_src_i.frame();
            for (int j = 1; j <= 4; j++) begin
                vca_scan_src_i.lines(1);
                c = (j == 1) ? s : c + (16'(p) << sh_t[m]);
                chk("mem_addr", mem_addr & mk_t[m], fetch(m, c) & mk_t[m]);
            end
        end
        // k=2: doubleword with count-by-four, one step in four ticks, rotated two
        for (int k = 0; k < 3; k++) begin
            start_address = 16'h0100;
            setup((k == 1) ? 8'hcb : 8'hc3, k[1] ? 8'h60 : 8'h00, 9'h000);
            vca_scan_src_i.frame();
            vca_scan_src_i.lines(1);
            vca_scan_src_i.chars(4);
            chk("char_step", mem_addr, k[1] ? 16'h0404 : k ? 16'h0102 : 16'h0104);
        end
        wreg(8'h07, 8'h10);
        wreg(8'h09, 8'h40);
        wreg(8'h12, 8'd10);
        wreg(8'h15, 8'd14);
        wreg(8'h16, 8'd20);
        // sweep past the blank window so no blank is left over from earlier modes
        vca_scan_src_i.lines(24);
        vca_scan_src_i.frame();
        vca_scan_src_i.lines(8);
        chk("disp_on", {15'h0, display_active}, 16'h0001);
        vca_scan_src_i.lines(4);
        chk("disp_off", {15'h0, display_active}, 16'h0000);
        chk("blank_pre", {15'h0, blank_active}, 16'h0000);
        vca_scan_src_i.lines(4);
        chk("blank_on", {15'h0, blank_active}, 16'h0001);
        vca_scan_src_i.lines(8);
        chk("blank_off", {15'h0, blank_active}, 16'h0000);
        wreg(8'h1b, 8'h20);
        wreg(8'h1a, 8'h40);
        vca_scan_src_i.frame();
        vca_scan_src_i.lines(1);
        chk("disp_again", {15'h0, display_active}, 16'h0001);
        vca_scan_src_i.lines(23);
        chk("blank_ext", {15'h0, blank_active}, 16'h0001);
        vca_scan_src_i.lines(260);
        chk("blank_ext_off", {15'h0, blank_active}, 16'h0000);
        wreg(8'h17, 8'hc7);
        vca_scan_src_i.frame();
        vca_scan_src_i.lines(16);
        chk("doubled", {15'h0, display_active}, 16'h0001);
        start_address = 16'h8000;
        setup(8'hc3, 8'h00, 9'h002);
        wreg(8'h07, 8'h02);
        wreg(8'h09, 8'h00);
        wreg(8'h18, 8'h03);
        vca_scan_src_i.frame();
        vca_scan_src_i.lines(8);
        chk("split", mem_addr, 16'h0010);
        test_done();
    end
endmodule : vca_crt_timing_controller_vert_bench
bind vca_crt_timing_controller_vert vca_crt_timing_controller_vert_chk #(.ROWS_PER_CELL(ROWS_PER_CELL)) vca_crt_timing_controller_vert_chk_i (
    .clk(clk), .rst_n(rst_n), .io_wr(io_wr), .io_rd(io_rd), .io_addr(io_addr),
    .io_wdata(io_wdata), .mono_mode(mono_mode), .text_mode(text_mode), .io_rvalid(io_rvalid),
    .mem_addr(mem_addr), .blank_active(blank_active), .display_active(display_active),
    .underline_line(underline_line), .row_scan(row_scan));
